// [vgof_pkg.sv]
// Package for the VF global translation table ownership filter.
// Assumes a single 200 MHz clock domain; no software-visible registers.
package vgof_pkg;
   // Window sizes, as byte-address widths
   localparam int unsigned VGOF_MMIO_AW    = 23;   // 8MB MMIO window per function
   localparam int unsigned VGOF_REGS_AW    = 22;   // 3MB of registers, rounded up to 4MB
   localparam logic [22:0] VGOF_REGS_LIMIT = 23'h300000; // 3MB used portion
   localparam int unsigned VGOF_BAR_AW     = 24;   // 16MB table-and-MMIO BAR per VF
   localparam int unsigned VGOF_GFX_AW     = 32;   // 4GB shared global address space
   localparam int unsigned VGOF_PAGE_SH    = 12;   // 4KB pages
   localparam int unsigned VGOF_PTE_W      = 64;   // table entry width
   localparam int unsigned VGOF_ENT_IDX_W  = VGOF_GFX_AW - VGOF_PAGE_SH;
   // Table entry field layout
   localparam int unsigned VGOF_PTE_VALID  = 0;
   localparam int unsigned VGOF_PTE_FN_LO  = 2;
   localparam int unsigned VGOF_PTE_FN_HI  = 7;
   localparam int unsigned VGOF_FN_W       = VGOF_PTE_FN_HI - VGOF_PTE_FN_LO + 1;
   localparam logic [5:0]  VGOF_PF_NUM     = 6'h00; // function 0 is the physical function
   // Replicated VF register subset (offsets in the VF window)
   localparam logic [22:0] VGOF_MBOX_BASE  = 23'h190000; // scheduler mailbox block
   localparam logic [22:0] VGOF_MBOX_SIZE  = 23'h001000;
   localparam logic [22:0] VGOF_P2V_BASE   = 23'h1C0000; // PF to VF channel block
   localparam logic [22:0] VGOF_P2V_SIZE   = 23'h001000;
   // Requester identity: bus and device fixed, function from VF number
   localparam logic [7:0]  VGOF_RID_BUS    = 8'h03;
   localparam logic [1:0]  VGOF_RID_DEV    = 2'h0;
   // Table access sequencer states
   typedef enum logic [1:0] {
      VGOF_ST_IDLE  = 2'b00,
      VGOF_ST_READ  = 2'b01,
      VGOF_ST_WRITE = 2'b10
   } vgof_state_e;
endpackage

// [vgof_engine_tag.sv]
// One engine's memory-request tagger: holds context attributes, flushes TLB.
// Assumes the submission port pulses once per context switch.
`timescale 1ns/1ps
`default_nettype none
module vgof_engine_tag
   import vgof_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   // Context submission
   input  wire logic                 ctx_load_i,
   input  wire logic [VGOF_FN_W-1:0] ctx_vf_i,
   input  wire logic [19:0]          ctx_pasid_i,
   input  wire logic [31:0]          ctx_dirptr_i,
   // Tags presented with memory requests
   output logic [19:0]               pasid_o,
   output logic [31:0]               dirptr_o,
   output logic [15:0]               rid_o,
   output logic                      tlb_flush_o
);
   logic [VGOF_FN_W-1:0] vf_q, vf_d;
   logic [19:0]          pasid_q, pasid_d;
   logic [31:0]          dir_q, dir_d;
   logic                 flush_q, flush_d;

   // Latch attributes on each switch and flag a flush
   always_comb begin
      vf_d    = ctx_load_i ? ctx_vf_i : vf_q;          // R13
      pasid_d = ctx_load_i ? ctx_pasid_i : pasid_q;
      dir_d   = ctx_load_i ? ctx_dirptr_i : dir_q;
      flush_d = ctx_load_i;                            // R16
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vf_q    <= '0;
         pasid_q <= '0;
         dir_q   <= '0;
         flush_q <= 1'b0;
      end else begin
         vf_q    <= vf_d;
         pasid_q <= pasid_d;
         dir_q   <= dir_d;
         flush_q <= flush_d;
      end
   end

   assign pasid_o     = pasid_q;                        // R15
   assign dirptr_o    = dir_q;
   assign rid_o       = {VGOF_RID_BUS, VGOF_RID_DEV, vf_q}; // R14
   assign tlb_flush_o = flush_q;
endmodule
`default_nettype wire

// [vgof_filter.sv]
// Ownership filter: decodes per-function windows, checks table entry owners,
// picks requester identities and tags engine contexts.
// Assumes the host bridge presents one request at a time, held until done.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Every function decodes an 8MB MMIO window of equal size.
// [R2] Registers live in the lowest 3MB; offsets above are unused.
// [R3] Each VF has one 16MB BAR holding MMIO and its table slice.
// [R4] One 4GB global address space is shared by all functions.
// [R5] Entries carry an owner; only that VF or the PF may access.
// [R6] Matching guest read returns the entry with owner field zeroed.
// [R7] Matching guest write keeps owner field and valid bit.
// [R8] Guest write to a foreign entry changes nothing.
// [R9] Guest read of a foreign entry returns zero.
// [R10] Aperture: table slice to guest physical, then by function identity.
// [R11] Aperture requester identity comes from the hit BAR; accesses overlap.
// [R12] PF access to a global page uses the entry's owner for translation.
// [R13] Submitted VF number joins context attributes toward the memory interface.
// [R14] Memory interface translates first by process, then by VF identity.
// [R15] Engines present process id, directory pointer and requester identity.
// [R16] Every engine context switch invalidates the TLBs.
// [R17] VF MMIO window exposes only the replicated register subset.
module vgof_filter
   import vgof_pkg::*;
#(
   parameter int unsigned NUM_ENG  = 4,
   parameter int unsigned TBL_DEPTH = 1024   // entries held locally
)(
   // Clock and reset
   input  wire logic                         ref_clk_i,
   input  wire logic                         nrst_i,
   // Host table-and-MMIO request
   input  wire logic                         host_req_i,
   input  wire logic                         host_we_i,
   input  wire logic [VGOF_FN_W-1:0]         host_fn_i,
   input  wire logic [VGOF_BAR_AW-1:0]       host_off_i,
   input  wire logic [VGOF_PTE_W-1:0]        host_wdata_i,
   output logic                              host_done_o,
   output logic [VGOF_PTE_W-1:0]             host_rdata_o,
   // MMIO forward to register blocks
   output logic                              mmio_fwd_o,
   output logic [VGOF_MMIO_AW-1:0]           mmio_off_o,
   output logic                              mmio_deny_o,
   // Aperture access
   input  wire logic                         ap_req_i,
   input  wire logic [VGOF_FN_W-1:0]         ap_fn_i,
   input  wire logic [VGOF_GFX_AW-1:0]       ap_gaddr_i,
   output logic                              ap_valid_o,
   output logic [VGOF_GFX_AW-1:0]            ap_gpa_o,
   output logic [15:0]                       ap_rid_o,
   output logic                              ap_fault_o,
   // Engine context submission
   input  wire logic [NUM_ENG-1:0]           ctx_load_i,
   input  wire logic [NUM_ENG*VGOF_FN_W-1:0] ctx_vf_i,
   input  wire logic [NUM_ENG*20-1:0]        ctx_pasid_i,
   input  wire logic [NUM_ENG*32-1:0]        ctx_dirptr_i,
   // Engine request tags
   output logic [NUM_ENG*20-1:0]             eng_pasid_o,
   output logic [NUM_ENG*32-1:0]             eng_dirptr_o,
   output logic [NUM_ENG*16-1:0]             eng_rid_o,
   output logic [NUM_ENG-1:0]                tlb_flush_o
);
   localparam int unsigned IW = $clog2(TBL_DEPTH);

   // Depth must be a power of two, or the page index would run past the array
   if (TBL_DEPTH < 2 || TBL_DEPTH > (1 << VGOF_ENT_IDX_W) || (1 << IW) != TBL_DEPTH
       || NUM_ENG < 1) begin : g_bad_param
      $error("vgof_filter: unsupported parameters");
   end

   // Reset release through two flops
   logic rst_s1_q, rst_n;
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // Local slice of the global table; 4GB space indexed by page
   logic [VGOF_PTE_W-1:0] tbl_mem [TBL_DEPTH];   // R4

   // Host request decode within the 16MB BAR: low 8MB MMIO, high 8MB table
   logic                    is_tbl;
   logic                    is_pf;
   logic [VGOF_MMIO_AW-1:0] moff;
   logic [IW-1:0]           tidx;
   logic                    reg_hit;
   logic                    sub_hit;
   always_comb begin
      is_tbl  = host_off_i[VGOF_BAR_AW-1];                            // R3
      is_pf   = (host_fn_i == VGOF_PF_NUM);
      moff    = host_off_i[VGOF_MMIO_AW-1:0];                         // R1
      tidx    = host_off_i[IW+2:3];
      reg_hit = (moff < VGOF_REGS_LIMIT);                             // R2
      sub_hit = ((moff >= VGOF_MBOX_BASE) && (moff < VGOF_MBOX_BASE + VGOF_MBOX_SIZE))
             || ((moff >= VGOF_P2V_BASE) && (moff < VGOF_P2V_BASE + VGOF_P2V_SIZE));
   end

   // MMIO forward: PF reaches all used registers, VF only the replicated subset
   logic                    fwd_q, fwd_d;
   logic                    deny_q, deny_d;
   logic [VGOF_MMIO_AW-1:0] moff_q, moff_d;
   vgof_state_e             state_q, state_d;
   logic                    done_q, done_d;
   // Done blocks the still-held request, so each access is forwarded once
   always_comb begin
      fwd_d  = 1'b0;
      deny_d = 1'b0;
      moff_d = moff_q;
      if (host_req_i && !is_tbl && !done_q && state_q == VGOF_ST_IDLE) begin
         moff_d = moff;
         if (reg_hit && (is_pf || sub_hit)) begin                   // R17
            fwd_d = 1'b1;
         end else begin
            deny_d = 1'b1;                                          // R2
         end
      end
   end

   // Table access sequencer: read entry, then answer or merge and write
   logic [IW-1:0]         idx_q, idx_d;
   logic [VGOF_PTE_W-1:0] wdat_q, wdat_d;
   logic [VGOF_FN_W-1:0]  fn_q, fn_d;
   logic [VGOF_PTE_W-1:0] ent_q, ent_d;
   logic [VGOF_PTE_W-1:0] rdat_q, rdat_d;
   logic                  mem_we;
   logic [VGOF_PTE_W-1:0] mem_wd;
   logic [VGOF_FN_W-1:0]  ent_fn;
   logic                  owner_ok;
   always_comb begin
      state_d  = state_q;
      idx_d    = idx_q;
      wdat_d   = wdat_q;
      fn_d     = fn_q;
      ent_d    = tbl_mem[idx_q];
      rdat_d   = rdat_q;
      done_d   = 1'b0;
      mem_we   = 1'b0;
      mem_wd   = ent_q;
      ent_fn   = ent_q[VGOF_PTE_FN_HI:VGOF_PTE_FN_LO];
      owner_ok = (ent_fn == fn_q);                                  // R5
      unique case (state_q)
         VGOF_ST_IDLE: begin
            if (host_req_i && !done_q) begin
               if (is_tbl) begin
                  idx_d   = tidx;
                  ent_d   = tbl_mem[tidx];   // Fetch now so the owner is known next cycle
                  wdat_d  = host_wdata_i;
                  fn_d    = host_fn_i;
                  state_d = host_we_i ? VGOF_ST_WRITE : VGOF_ST_READ;
               end else begin
                  done_d = 1'b1;
               end
            end
         end
         VGOF_ST_READ: begin
            if (fn_q == VGOF_PF_NUM) begin
               rdat_d = ent_q;                                      // R5
            end else if (owner_ok) begin
               rdat_d = ent_q;
               rdat_d[VGOF_PTE_FN_HI:VGOF_PTE_FN_LO] = '0;          // R6
            end else begin
               rdat_d = '0;                                         // R9
            end
            done_d  = 1'b1;
            state_d = VGOF_ST_IDLE;
         end
         VGOF_ST_WRITE: begin
            if (fn_q == VGOF_PF_NUM) begin
               mem_we = 1'b1;
               mem_wd = wdat_q;
            end else if (owner_ok) begin
               mem_we = 1'b1;                                       // R7
               mem_wd = wdat_q;
               mem_wd[VGOF_PTE_FN_HI:VGOF_PTE_FN_LO] = ent_fn;
               mem_wd[VGOF_PTE_VALID] = ent_q[VGOF_PTE_VALID];
            end                                                     // R8
            done_d  = 1'b1;
            state_d = VGOF_ST_IDLE;
         end
         default: state_d = VGOF_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= VGOF_ST_IDLE;
         idx_q   <= '0;
         wdat_q  <= '0;
         fn_q    <= '0;
         ent_q   <= '0;
         rdat_q  <= '0;
         done_q  <= 1'b0;
         fwd_q   <= 1'b0;
         deny_q  <= 1'b0;
         moff_q  <= '0;
      end else begin
         state_q <= state_d;
         idx_q   <= idx_d;
         wdat_q  <= wdat_d;
         fn_q    <= fn_d;
         ent_q   <= ent_d;
         rdat_q  <= rdat_d;
         done_q  <= done_d;
         fwd_q   <= fwd_d;
         deny_q  <= deny_d;
         moff_q  <= moff_d;
      end
   end

   // Table storage has no reset; software initialises entries before use
   always_ff @(posedge ref_clk_i) begin
      if (mem_we) begin
         tbl_mem[idx_q] <= mem_wd;
      end
   end

   assign host_done_o  = done_q;
   assign host_rdata_o = rdat_q;
   assign mmio_fwd_o   = fwd_q;
   assign mmio_deny_o  = deny_q;
   assign mmio_off_o   = moff_q;

   // Aperture path: one lookup per cycle, pipelined, so functions overlap
   logic                   apv_q, apv_d;
   logic [VGOF_FN_W-1:0]   apfn_q, apfn_d;
   logic [IW-1:0]          apidx_q, apidx_d;
   logic [VGOF_PAGE_SH-1:0] apoff_q, apoff_d;
   logic [VGOF_PTE_W-1:0]  apent;
   logic [VGOF_FN_W-1:0]   apown;
   logic                   ap_ok;
   logic                   aov_q, aov_d;
   logic                   aflt_q, aflt_d;
   logic [VGOF_GFX_AW-1:0] agpa_q, agpa_d;
   logic [15:0]            arid_q, arid_d;
   always_comb begin
      apv_d   = ap_req_i;
      apfn_d  = ap_fn_i;                                            // R11
      apidx_d = ap_gaddr_i[IW+VGOF_PAGE_SH-1:VGOF_PAGE_SH];
      apoff_d = ap_gaddr_i[VGOF_PAGE_SH-1:0];
      apent   = tbl_mem[apidx_q];
      apown   = apent[VGOF_PTE_FN_HI:VGOF_PTE_FN_LO];
      ap_ok   = apent[VGOF_PTE_VALID] && ((apfn_q == VGOF_PF_NUM) || (apown == apfn_q)); // R5
      aov_d   = apv_q && ap_ok;
      aflt_d  = apv_q && !ap_ok;
      agpa_d  = {apent[VGOF_GFX_AW-1:VGOF_PAGE_SH], apoff_q};       // R10
      // PF use of a page is translated as its owning function
      arid_d  = {VGOF_RID_BUS, VGOF_RID_DEV,
                 (apfn_q == VGOF_PF_NUM) ? apown : apfn_q};         // R12
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         apv_q   <= 1'b0;
         apfn_q  <= '0;
         apidx_q <= '0;
         apoff_q <= '0;
         aov_q   <= 1'b0;
         aflt_q  <= 1'b0;
         agpa_q  <= '0;
         arid_q  <= '0;
      end else begin
         apv_q   <= apv_d;
         apfn_q  <= apfn_d;
         apidx_q <= apidx_d;
         apoff_q <= apoff_d;
         aov_q   <= aov_d;
         aflt_q  <= aflt_d;
         agpa_q  <= agpa_d;
         arid_q  <= arid_d;
      end
   end

   assign ap_valid_o = aov_q;
   assign ap_fault_o = aflt_q;
   assign ap_gpa_o   = agpa_q;
   assign ap_rid_o   = arid_q;

   // One tagger per engine; engines may run contexts of different VFs
   for (genvar e = 0; e < NUM_ENG; e++) begin : g_eng
      vgof_engine_tag u_tag (
         .clk_i        (ref_clk_i),
         .rst_n_i      (rst_n),
         .ctx_load_i   (ctx_load_i[e]),
         .ctx_vf_i     (ctx_vf_i[e*VGOF_FN_W +: VGOF_FN_W]),      // R13
         .ctx_pasid_i  (ctx_pasid_i[e*20 +: 20]),
         .ctx_dirptr_i (ctx_dirptr_i[e*32 +: 32]),
         .pasid_o      (eng_pasid_o[e*20 +: 20]),                 // R15
         .dirptr_o     (eng_dirptr_o[e*32 +: 32]),
         .rid_o        (eng_rid_o[e*16 +: 16]),                   // R14
         .tlb_flush_o  (tlb_flush_o[e])                            // R16
      );
   end
endmodule
`default_nettype wire

// [vgof_checker.sv]
// Concurrent checks on the ownership filter's host, aperture and engine ports.
// Assumes the host bridge holds a request until done and leaves a gap after it.
`timescale 1ns/1ps
`default_nettype none
module vgof_checker
   import vgof_pkg::*;
#(
   parameter int unsigned NUM_ENG = 4
)(
   // Clock and reset
   input wire logic                         ref_clk_i,
   input wire logic                         nrst_i,
   // Host side
   input wire logic                         host_req_i,
   input wire logic [VGOF_FN_W-1:0]         host_fn_i,
   input wire logic [VGOF_BAR_AW-1:0]       host_off_i,
   input wire logic                         host_done_o,
   input wire logic                         mmio_fwd_o,
   input wire logic [VGOF_MMIO_AW-1:0]      mmio_off_o,
   input wire logic                         mmio_deny_o,
   // Aperture
   input wire logic                         ap_req_i,
   input wire logic [VGOF_FN_W-1:0]         ap_fn_i,
   input wire logic                         ap_valid_o,
   input wire logic                         ap_fault_o,
   input wire logic [15:0]                  ap_rid_o,
   // Engines
   input wire logic [NUM_ENG-1:0]           ctx_load_i,
   input wire logic [NUM_ENG*VGOF_FN_W-1:0] ctx_vf_i,
   input wire logic [NUM_ENG*20-1:0]        ctx_pasid_i,
   input wire logic [NUM_ENG*20-1:0]        eng_pasid_o,
   input wire logic [NUM_ENG*16-1:0]        eng_rid_o,
   input wire logic [NUM_ENG-1:0]           tlb_flush_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // Offset lands in the replicated mailbox or channel block
   logic in_sub;
   assign in_sub = (host_off_i[22:0] >= VGOF_MBOX_BASE
                    && host_off_i[22:0] < VGOF_MBOX_BASE + VGOF_MBOX_SIZE)
                   || (host_off_i[22:0] >= VGOF_P2V_BASE
                    && host_off_i[22:0] < VGOF_P2V_BASE + VGOF_P2V_SIZE);
   // Host table and MMIO answers
   tbl_done_a: assert property ($rose(host_req_i) && host_off_i[23] |->
      !host_done_o ##1 !host_done_o ##1 host_done_o) else $error("table done late");
   done_pulse_a: assert property (host_done_o |=> !host_done_o)
      else $error("done longer than one cycle");
   mmio_limit_a: assert property ($rose(host_req_i) && !host_off_i[23]
      && host_off_i[22:0] >= VGOF_REGS_LIMIT |=> mmio_deny_o && host_done_o && !mmio_fwd_o)
      else $error("unused MMIO offset not denied");
   vf_subset_a: assert property ($rose(host_req_i) && !host_off_i[23]
      && host_fn_i != VGOF_PF_NUM && !in_sub |=> mmio_deny_o && !mmio_fwd_o)
      else $error("VF reached a register outside its subset");
   pf_fwd_a: assert property ($rose(host_req_i) && !host_off_i[23]
      && host_fn_i == VGOF_PF_NUM && host_off_i[22:0] < VGOF_REGS_LIMIT
      |=> mmio_fwd_o && mmio_off_o == $past(host_off_i[22:0]))
      else $error("PF MMIO access not forwarded");
   // Aperture answers two cycles on, identity from the hit BAR
   ap_answer_a: assert property (ap_req_i |-> ##2 (ap_valid_o != ap_fault_o))
      else $error("aperture answer missing");
   ap_rid_a: assert property (ap_req_i && ap_fn_i != VGOF_PF_NUM ##2 ap_valid_o
      |-> ap_rid_o == {VGOF_RID_BUS, VGOF_RID_DEV, $past(ap_fn_i, 2)})
      else $error("aperture identity wrong");
   // Engine flush and tags
   flush_a: assert property ((|ctx_load_i) |=> tlb_flush_o == $past(ctx_load_i))
      else $error("flush does not follow context load");
   eng_rid_a: assert property (ctx_load_i[0] |=> eng_rid_o[15:0] ==
      {VGOF_RID_BUS, VGOF_RID_DEV, $past(ctx_vf_i[VGOF_FN_W-1:0])}
      && eng_pasid_o[19:0] == $past(ctx_pasid_i[19:0])) else $error("engine tags wrong");
   eng_hold_a: assert property (!ctx_load_i[0] |=> $stable(eng_rid_o[15:0]))
      else $error("engine identity changed without load");
   // Main scenarios reached
   cov_tbl_c: cover property ($rose(host_req_i) && host_off_i[23]);
   cov_deny_c: cover property (mmio_deny_o);
   cov_fault_c: cover property (ap_fault_o);
   cov_flush_c: cover property (tlb_flush_o[0]);
endmodule
bind vgof_filter vgof_checker #(.NUM_ENG(NUM_ENG)) u_chk (.ref_clk_i, .nrst_i,
   .host_req_i, .host_fn_i, .host_off_i, .host_done_o, .mmio_fwd_o, .mmio_off_o,
   .mmio_deny_o, .ap_req_i, .ap_fn_i, .ap_valid_o, .ap_fault_o, .ap_rid_o, .ctx_load_i,
   .ctx_vf_i, .ctx_pasid_i, .eng_pasid_o, .eng_rid_o, .tlb_flush_o);
`default_nettype wire

// [vgof_host_model.sv]
// Host bridge model: one table or MMIO request at a time toward the filter.
// Assumes one clock; the caller waits for the task before the next access.
`timescale 1ns/1ps
`default_nettype none
module vgof_host_model (
   // Clock
   input  wire logic        clk_i,
   // Answer from the filter
   input  wire logic        done_i,
   input  wire logic        fwd_i,
   input  wire logic        deny_i,
   input  wire logic [63:0] rdata_i,
   // Request to the filter
   output var logic         req_o,
   output var logic         we_o,
   output var logic [5:0]   fn_o,
   output var logic [23:0]  off_o,
   output var logic [63:0]  wdata_o
);
   // Idle bus at time zero
   initial begin
      req_o = 1'b0;
      we_o = 1'b0;
      fn_o = 6'h00;
      off_o = 24'h000000;
      wdata_o = 64'h0;
   end
   // Hold everything until done is sampled or 16 cycles pass, then drop req and scramble offset and data
   task automatic access(input logic we, input logic [5:0] fn, input logic [23:0] off,
      input logic [63:0] wd, output logic [63:0] rd, output logic [1:0] fd, output logic got);
      got = 1'b0;
      @(posedge clk_i);
      req_o <= 1'b1;
      we_o <= we;
      fn_o <= fn;
      off_o <= off;
      wdata_o <= wd;
      for (int n = 0; n < 16 && !got; n++) begin
         @(posedge clk_i);
         got = done_i;
      end
      rd = rdata_i;
      fd = {fwd_i, deny_i};
      req_o <= 1'b0;
      off_o <= ~off;    // Released lines must not look like a held address
      wdata_o <= ~wd;
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the ownership filter with a host bridge model.
// Assumes NUM_ENG of 4 and a locally held slice of 16 entries.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module testbench;
   import vgof_pkg::*;
   localparam int unsigned NE = 4;
   logic ref_clk_i = 1'b0;
   logic nrst_i, host_req_i, host_we_i, host_done_o, mmio_fwd_o, mmio_deny_o;
   logic ap_req_i, ap_valid_o, ap_fault_o;
   logic [5:0]       host_fn_i, ap_fn_i;
   logic [23:0]      host_off_i;
   logic [63:0]      host_wdata_i, host_rdata_o;
   logic [22:0]      mmio_off_o;
   logic [31:0]      ap_gaddr_i, ap_gpa_o, r;
   logic [15:0]      ap_rid_o;
   logic [127:0]     w;
   logic [NE-1:0]    ctx_load_i, tlb_flush_o, ld_q = '0;
   logic [NE*6-1:0]  ctx_vf_i, vf_q;
   logic [NE*20-1:0] ctx_pasid_i, eng_pasid_o, pa_q;
   logic [NE*32-1:0] ctx_dirptr_i, eng_dirptr_o, dp_q;
   logic [NE*16-1:0] eng_rid_o;
   logic [49:0]      ap_p0 = '0, ap_p1 = '0;
   logic [63:0]      tbl [16];
   logic [28:0]      mc [10] = '{{6'h00, 23'h000000}, {6'h00, 23'h2FFFFF},
      {6'h00, 23'h300000}, {6'h00, 23'h7FFFFF}, {6'h01, 23'h190000}, {6'h02, 23'h190FFF},
      {6'h03, 23'h191000}, {6'h01, 23'h1C0FFF}, {6'h02, 23'h1BFFFF}, {6'h01, 23'h000100}};
   int seed = 10;
   int bad_count = 0;
   int checked = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   vgof_filter #(.NUM_ENG(NE), .TBL_DEPTH(16)) dut (.ref_clk_i, .nrst_i, .host_req_i,
      .host_we_i, .host_fn_i, .host_off_i, .host_wdata_i, .host_done_o, .host_rdata_o,
      .mmio_fwd_o, .mmio_off_o, .mmio_deny_o, .ap_req_i, .ap_fn_i, .ap_gaddr_i, .ap_valid_o,
      .ap_gpa_o, .ap_rid_o, .ap_fault_o, .ctx_load_i, .ctx_vf_i, .ctx_pasid_i, .ctx_dirptr_i,
      .eng_pasid_o, .eng_dirptr_o, .eng_rid_o, .tlb_flush_o);
   vgof_host_model host (.clk_i(ref_clk_i), .done_i(host_done_o), .fwd_i(mmio_fwd_o),
      .deny_i(mmio_deny_o), .rdata_i(host_rdata_o), .req_o(host_req_i), .we_o(host_we_i),
      .fn_o(host_fn_i), .off_o(host_off_i), .wdata_o(host_wdata_i));
   // Expected entry seen by a reader, and entry after a write
   function automatic logic [63:0] rd_exp(input logic [5:0] fn, input logic [63:0] e);
      if (fn == VGOF_PF_NUM) return e;
      if (e[7:2] != fn) return 64'h0;
      return {e[63:8], 6'h00, e[1:0]};
   endfunction
   function automatic logic [63:0] wr_exp(input logic [5:0] fn, input logic [63:0] e,
      input logic [63:0] d);
      if (fn == VGOF_PF_NUM) return d;
      if (e[7:2] != fn) return e;
      return {d[63:8], e[7:2], d[1], e[0]};
   endfunction
   function automatic logic mm_ok(input logic [5:0] fn, input logic [22:0] o);
      return o < VGOF_REGS_LIMIT && (fn == VGOF_PF_NUM || o[22:12] == 11'h190
         || o[22:12] == 11'h1C0);
   endfunction
   // Aperture outcome: {check, fault, gpa, rid}
   function automatic logic [49:0] ap_exp(input logic [5:0] fn, input logic [31:0] ga);
      logic [63:0] e;
      e = tbl[ga[15:12]];
      return {1'b1, !e[0] || (fn != VGOF_PF_NUM && e[7:2] != fn), e[31:12], ga[11:0],
         VGOF_RID_BUS, VGOF_RID_DEV, (fn == VGOF_PF_NUM) ? e[7:2] : fn};
   endfunction
   // Random entry owned by one of functions 0..3
   function automatic logic [63:0] rnd_ent();
      logic [63:0] v;
      v = {$random(seed), $random(seed)};
      v[7:2] = {4'h0, v[9:8]};
      return v;
   endfunction
   task automatic tbl_op(input logic we, input logic [5:0] fn, input logic [3:0] idx,
      input logic [63:0] wd);
      logic [63:0] rd;
      logic [1:0] fd;
      logic got;
      host.access(we, fn, {1'b1, 16'h0000, idx, 3'h0}, wd, rd, fd, got);
      `CHK(got, 1'b1)
      if (we) tbl[idx] = wr_exp(fn, tbl[idx], wd);
      else `CHK(rd, rd_exp(fn, tbl[idx]))
   endtask
   task automatic mm_op(input logic [5:0] fn, input logic [22:0] o);
      logic [63:0] rd;
      logic [1:0] fd;
      logic got;
      host.access(1'b0, fn, {1'b0, o}, 64'h0, rd, fd, got);
      `CHK({got, fd}, {1'b1, mm_ok(fn, o), !mm_ok(fn, o)})
      if (mm_ok(fn, o)) `CHK(mmio_off_o, o)
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Aperture answers and engine tags, compared against values sampled earlier
   always @(posedge ref_clk_i) begin
      if (ap_p1[49]) begin
         `CHK({ap_valid_o, ap_fault_o}, {!ap_p1[48], ap_p1[48]})
         if (!ap_p1[48]) `CHK({ap_gpa_o, ap_rid_o}, ap_p1[47:0])
      end
      if (nrst_i) `CHK(tlb_flush_o, ld_q)
      for (int e = 0; e < NE; e++) if (ld_q[e]) `CHK({eng_rid_o[e*16+:16],
         eng_pasid_o[e*20+:20], eng_dirptr_o[e*32+:32]}, {VGOF_RID_BUS, VGOF_RID_DEV,
         vf_q[e*6+:6], pa_q[e*20+:20], dp_q[e*32+:32]})
      ap_p1 = ap_p0;
      ap_p0 = ap_req_i ? ap_exp(ap_fn_i, ap_gaddr_i) : 50'h0;
      ld_q = ctx_load_i;
      vf_q = ctx_vf_i;
      pa_q = ctx_pasid_i;
      dp_q = ctx_dirptr_i;
   end
   // Watchdog well beyond the expected 750 or so cycles
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      bad_count++;
      close_out();
   end
   // Main sequence; table memory powers up unknown, so the PF writes every entry first
   initial begin
      {nrst_i, ap_req_i, ap_fn_i, ap_gaddr_i, ctx_load_i} = '0;
      {ctx_vf_i, ctx_pasid_i, ctx_dirptr_i} = '0;
      repeat (12) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      for (int i = 0; i < 16; i++) tbl_op(1'b1, VGOF_PF_NUM, 4'(i), rnd_ent());
      for (int i = 0; i < 80; i++) begin
         r = $random(seed);
         tbl_op(r[2], {4'h0, r[1:0]}, r[6:3], rnd_ent());
      end
      tbl_op(1'b1, VGOF_PF_NUM, 4'hF, 64'h0000_0000_ABCD_E008);
      tbl_op(1'b1, 6'h02, 4'hF, 64'hFFFF_FFFF_FFFF_FFFF);
      tbl_op(1'b1, 6'h01, 4'hF, 64'h0);
      tbl_op(1'b0, 6'h02, 4'hF, 64'h0);
      tbl_op(1'b0, VGOF_PF_NUM, 4'hF, 64'h0);
      foreach (mc[k]) mm_op(mc[k][28:23], mc[k][22:0]);
      repeat (300) @(posedge ref_clk_i) begin
         r = $random(seed);
         w = {$random(seed), $random(seed), $random(seed), $random(seed)};
         ap_req_i <= r[0];
         ap_fn_i <= {4'h0, r[2:1]};
         ap_gaddr_i <= {16'h0000, r[31:16]};
         ctx_load_i <= r[NE+3:4];
         ctx_vf_i <= w[NE*6-1:0];
         ctx_pasid_i <= w[NE*20+7:8];
         ctx_dirptr_i <= w;
      end
      ap_req_i <= 1'b0;
      ctx_load_i <= '0;
      repeat (4) @(posedge ref_clk_i);
      close_out();
   end
endmodule
`default_nettype wire
